// [spc_consts.svh]
// shared pin control constants: register offsets, field positions, reset values
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_NPINS 55
`define SPC_ADDR_W 4
`define SPC_OFF_DIR 4'h0
`define SPC_OFF_LATCH 4'h1
`define SPC_OFF_PULLEN 4'h2
`define SPC_OFF_DATA 4'h3
`define SPC_OFF_KBI_EDGE 4'h4
`define SPC_OFF_IRQ_CTRL 4'h5
`define SPC_OFF_PERIPH_OE 4'h6
`define SPC_OFF_PAD_OE 4'h7
`define SPC_OFF_PULL_ON 4'h8
`define SPC_OFF_PULL_DN 4'h9
`define SPC_IRQ_PE_BIT 0
`define SPC_IRQ_RISE_BIT 1
`define SPC_KBI_UP_LSB 4
`define SPC_KBI_UP_MSB 7
`define SPC_RST_VEC 55'h0
`endif

// [spc_pkg.sv]
// shared pin control types
package spc_pkg;
  typedef logic [54:0] spc_pins_t;
  typedef enum logic [1:0]
  {
    SPC_IDLE = 2'b00,
    SPC_ACK = 2'b01
  } spc_bus_e;
endpackage : spc_pkg

// [spc_pad_logic.sv]
// per-pin pad steering: output enable owner, read mux, pull enable and pull polarity
`timescale 1ns/1ps
`include "spc_consts.svh"
module spc_pad_logic
  import spc_pkg::*;
(
  input wire spc_pins_t dir,
  input wire spc_pins_t latch,
  input wire spc_pins_t pull_en,
  input wire spc_pins_t periph_act,
  input wire spc_pins_t periph_oe,
  input wire spc_pins_t periph_out,
  input wire spc_pins_t pad_in,
  input wire logic [3:0] kbi_upper_rise,
  input wire logic [3:0] kbi_upper_act,
  output spc_pins_t pad_out,
  output spc_pins_t pad_oe_n,
  output spc_pins_t pull_on,
  output spc_pins_t pull_down,
  output spc_pins_t read_val
);
  spc_pins_t drive;
  always_comb
  begin
    drive = (periph_act & periph_oe) | (~periph_act & dir);
    pad_oe_n = ~drive;
    pad_out = (periph_act & periph_out) | (~periph_act & latch);
    read_val = (dir & latch) | (~dir & pad_in);
    pull_on = pull_en & ~drive;
    pull_down = '0;
    pull_down[`SPC_KBI_UP_MSB:`SPC_KBI_UP_LSB] = kbi_upper_act & kbi_upper_rise;
  end
endmodule : spc_pad_logic

// [spc_pin_ctrl.sv]
// shared pin control top: wishbone register file, pad steering and external irq pin pulls
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "spc_consts.svh"
// How it works
// - after reset every pin not driven by an active peripheral is an input, and all pull devices are off.
// - the direction bit picks pin level or output latch for latch reads even under a peripheral.
// - an active peripheral, not the direction bit, owns the pin's output enable.
// - the pull-enable bit turns on the pull device whenever the pin is an input.
// - upper keyboard pins set for rising or high level get a pulldown instead of a pullup.
// - the irq pin set for rising edges gets a pulldown instead of a pullup.
// - the irq pin function stays off until its pin-enable bit is one.
// - with the irq function enabled its pull is forced on, as a pullup for falling edges.
module spc_pin_ctrl
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire spc_pins_t periph_act,
  input wire spc_pins_t periph_oe,
  input wire spc_pins_t periph_out,
  input wire logic [3:0] kbi_upper_act,
  input wire spc_pins_t pad_in,
  output spc_pins_t pad_out,
  output spc_pins_t pad_oe_n,
  output spc_pins_t pull_on,
  output spc_pins_t pull_down,
  input wire logic irq_pad_in,
  output logic irq_pull_on,
  output logic irq_pull_down,
  output logic irq_active,
  output logic irq_level
);
  spc_pins_t dir_r;
  spc_pins_t latch_r;
  spc_pins_t pull_en_r;
  logic [3:0] kbi_rise_r;
  logic irq_pe_r;
  logic irq_rise_r;
  logic irq_pull_en_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  spc_pins_t read_val;
  spc_pins_t oe_n_w;
  spc_pins_t pull_on_w;
  spc_pins_t pull_dn_w;
  logic req;
  logic [3:0] adr;
  logic wr_fire;
  logic wr_dir;
  logic wr_latch;
  logic wr_pull;
  logic wr_mode;

  // 55-bit registers span two words: index n uses offset*2 for low, +1 word above
  function automatic spc_pins_t wr_pins(input spc_pins_t cur, input logic hi,
                                        input logic [31:0] d, input logic [3:0] sel);
    spc_pins_t v;
    v = cur;
    // a byte lane whose sel bit is low leaves those pins unchanged
    for (int i = 0; i < 32; i++)
    begin
      if (!hi && sel[i/8])
        v[i] = d[i];
    end
    // the upper word holds only pins 54:32
    for (int i = 0; i < 23; i++)
    begin
      if (hi && sel[i/8])
        v[32+i] = d[i];
    end
    return v;
  endfunction : wr_pins

  function automatic logic [31:0] rd_pins(input spc_pins_t v, input logic hi);
    rd_pins = hi ? {9'h000, v[54:32]} : v[31:0];
  endfunction : rd_pins

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  // bit 2 of the word address selects low or high half of the pin vectors
  assign adr = {1'b0, wb_adr_i[5:3]};

  // writes land on the edge where the master sees ack, the same edge at which it
  // releases the request, so address and data are still valid there
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign wr_dir = wr_fire && (adr == `SPC_OFF_DIR);
  assign wr_latch = wr_fire && (adr == `SPC_OFF_LATCH);
  assign wr_pull = wr_fire && (adr == `SPC_OFF_PULLEN);
  assign wr_mode = wr_fire && (adr == `SPC_OFF_KBI_EDGE) && !wb_adr_i[2] && wb_sel_i[0];

  spc_pad_logic u_pad
  (
    .dir(dir_r),
    .latch(latch_r),
    .pull_en(pull_en_r),
    .periph_act(periph_act),
    .periph_oe(periph_oe),
    .periph_out(periph_out),
    .pad_in(pad_in),
    .kbi_upper_rise(kbi_rise_r),
    .kbi_upper_act(kbi_upper_act),
    .pad_out(pad_out),
    .pad_oe_n(oe_n_w),
    .pull_on(pull_on_w),
    .pull_down(pull_dn_w),
    .read_val(read_val)
  );

  assign pad_oe_n = oe_n_w;
  assign pull_on = pull_on_w;
  // a pulldown request means nothing while the pull is off, so it is masked here
  assign pull_down = pull_dn_w & pull_on_w;

  // pin registers reset to inputs with every pull off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dir_r <= `SPC_RST_VEC;
    else if (wr_dir)
      dir_r <= wr_pins(dir_r, wb_adr_i[2], wb_dat_i, wb_sel_i);
  end

  // the latch keeps its value under a peripheral, so the port level returns when it lets go
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      latch_r <= `SPC_RST_VEC;
    else if (wr_latch)
      latch_r <= wr_pins(latch_r, wb_adr_i[2], wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pull_en_r <= `SPC_RST_VEC;
    else if (wr_pull)
      pull_en_r <= wr_pins(pull_en_r, wb_adr_i[2], wb_dat_i, wb_sel_i);
  end

  // mode word at index 4 (address 0x20): kbi rising bits and irq control
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      kbi_rise_r <= 4'h0;
    else if (wr_mode)
      kbi_rise_r <= wb_dat_i[`SPC_KBI_UP_MSB:`SPC_KBI_UP_LSB];
  end

  // irq control: the pull follows the enable alone, the spare bit never reaches the pad
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_pe_r <= 1'b0;
      irq_rise_r <= 1'b0;
      irq_pull_en_r <= 1'b0;
    end
    else if (wr_mode)
    begin
      irq_pe_r <= wb_dat_i[`SPC_IRQ_PE_BIT];
      irq_rise_r <= wb_dat_i[`SPC_IRQ_RISE_BIT];
      // spare cell kept only so software reads back what it wrote
      irq_pull_en_r <= wb_dat_i[2];
    end
  end

  // irq pad has no output driver, so its pull only depends on the function state
  always_comb
  begin
    irq_active = irq_pe_r;
    irq_pull_on = irq_pe_r;
    irq_pull_down = irq_pe_r & irq_rise_r;
    // the pin in its asserted sense, held low while the function is off
    irq_level = irq_pe_r & (irq_pad_in ^ ~irq_rise_r);
  end

  always_comb
  begin
    rdata_nxt = 32'h0;
    case (adr)
      `SPC_OFF_DIR: rdata_nxt = rd_pins(dir_r, wb_adr_i[2]);
      `SPC_OFF_LATCH: rdata_nxt = rd_pins(read_val, wb_adr_i[2]);
      `SPC_OFF_PULLEN: rdata_nxt = rd_pins(pull_en_r, wb_adr_i[2]);
      `SPC_OFF_DATA: rdata_nxt = rd_pins(pad_in, wb_adr_i[2]);
      // mode word reads back bits 7:4 and 2:0 as written; bit 3 and bits 31:8 read zero; its upper word reads zero
      `SPC_OFF_KBI_EDGE: rdata_nxt = wb_adr_i[2] ? 32'h0 :
        {24'h0, kbi_rise_r, 1'b0, irq_pull_en_r, irq_rise_r, irq_pe_r};
      `SPC_OFF_PERIPH_OE: rdata_nxt = rd_pins(~oe_n_w, wb_adr_i[2]);
      default: rdata_nxt = 32'h0;
    endcase
  end

  // ack is a one-cycle pulse; req masks the ack cycle so one request is never taken twice
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  // read data is captured with the request and stands until the next one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0;
    else if (req)
      rdata_r <= rdata_nxt;
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
endmodule : spc_pin_ctrl

// [spc_checker.sv]
// port assertions for the shared pin control block
`timescale 1ns/1ps
module spc_checker
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] kbi_upper_act,
  input wire spc_pins_t periph_act,
  input wire spc_pins_t periph_oe,
  input wire spc_pins_t pad_oe_n,
  input wire spc_pins_t pull_on,
  input wire spc_pins_t pull_down,
  input wire logic irq_pull_on,
  input wire logic irq_pull_down,
  input wire logic irq_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RST_IDLE: assert property ($rose(rst_n) |-> &pad_oe_n && pull_on == '0)
    else $error("pins not idle after reset");
  AST_OE_OWNER: assert property ((periph_act & ~pad_oe_n) == (periph_act & periph_oe))
    else $error("peripheral does not own drive");
  AST_PULL_DRIVEN: assert property ((pull_on & ~pad_oe_n) == '0)
    else $error("pull on a driven pin");
  AST_PULL_DN_KBI: assert property ((pull_down & pull_on & ~55'({kbi_upper_act, 4'h0})) == '0)
    else $error("pulldown outside keyboard pins");
  AST_IRQ_OFF: assert property (!irq_active |-> !irq_pull_on && !irq_pull_down)
    else $error("irq pull while disabled");
  AST_IRQ_PULL: assert property (irq_active |-> irq_pull_on)
    else $error("irq pull off while enabled");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  cover property (irq_pull_down);
  cover property (pull_down != '0);
  cover property ((periph_act & ~pad_oe_n) != '0);
endmodule : spc_checker
bind spc_pin_ctrl spc_checker spc_checker_inst (.*);

// [spc_board.sv]
// board model: resolves pad levels from drive and pulls
`timescale 1ns/1ps
module spc_board
  import spc_pkg::*;
(
  input wire logic clk,
  input wire spc_pins_t pad_out,
  input wire spc_pins_t pad_oe_n,
  input wire spc_pins_t pull_on,
  input wire spc_pins_t pull_down,
  output spc_pins_t pad_in
);
  // floating pins toggle so a stale level never passes for a read
  spc_pins_t float_r = '0;
  always @(posedge clk)
  begin
    float_r <= ~float_r;
  end
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & pull_on & ~pull_down)
    | (pad_oe_n & ~pull_on & float_r);
endmodule : spc_board

// [tb_spc_pin_ctrl.sv]
// self-checking bench for the shared pin control block
`timescale 1ns/1ps
module tb_spc_pin_ctrl
  import spc_pkg::*;
  ;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_pad_in;
  logic irq_pull_on, irq_pull_down, irq_active, irq_level;
  logic [5:2] wb_adr_i;
  logic [3:0] wb_sel_i, kbi_upper_act;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  spc_pins_t periph_act, periph_oe, periph_out, pad_in, pad_out, pad_oe_n, pull_on, pull_down;
  int mismatches, num_checks;
  // act, oe, dir, pull enable, expected oe_n, pull, latch read
  logic [31:0] rows [3][7] = '{
    '{0, 0, 32'h0000ffff, 32'hffffffff, 32'hffff0000, 32'hffff0000, 32'hffff00ff},
    '{32'hffffffff, 32'h00ff00ff, 32'h0000ffff, 32'hffffffff, 32'hff00ff00,
      32'hff00ff00, 32'hff0000ff},
    '{0, 0, 32'hffffffff, 32'hffffffff, 0, 0, 32'h00ff00ff}};
  spc_pin_ctrl spc_pin_ctrl_inst (.*);
  spc_board spc_board_inst (.*);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk);
  endtask : bus
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #20us;
    mismatches++;
    conclude();
  end
  initial
  begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, irq_pad_in, kbi_upper_act} = '0;
    {periph_act, periph_oe, periph_out} = '0;
    wb_sel_i = 4'hf;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk(&pad_oe_n && !pull_on && !irq_active, 1'b1);
    bus(0, 4'h0, 32'h0);
    chk(q, 32'h0);
    bus(1, 4'h2, 32'h00ff00ff);
    foreach (rows[i])
    begin
      periph_act <= 55'(rows[i][0]);
      periph_oe <= 55'(rows[i][1]);
      bus(1, 4'h0, rows[i][2]);
      bus(1, 4'h4, rows[i][3]);
      chk(pad_oe_n[31:0], rows[i][4]);
      chk(pull_on[31:0], rows[i][5]);
      bus(0, 4'h2, 32'h0);
      chk(q, rows[i][6]);
      $display("row %0d done", i);
    end
    periph_act <= '0;
    kbi_upper_act <= 4'hf;
    bus(1, 4'h0, 32'h0);
    bus(1, 4'h8, 32'h53);
    chk(pull_down[7:4], 4'h5);
    chk({irq_active, irq_pull_on, irq_pull_down}, 3'h7);
    bus(0, 4'h6, 32'h0);
    chk(q, 32'hffffffaf);
    bus(0, 4'h8, 32'h0);
    chk(q, 32'h00000053);
    irq_pad_in <= 1'b1;
    @(posedge clk);
    chk(irq_level, 1'b1);
    bus(1, 4'h8, 32'h1);
    chk({irq_active, irq_pull_on, irq_pull_down}, 3'h6);
    chk(irq_level, 1'b0);
    bus(1, 4'h8, 32'h0);
    chk({irq_active, irq_pull_on, irq_pull_down, irq_level}, 4'h0);
    bus(1, 4'hf, 32'hffffffff);
    bus(0, 4'hf, 32'h0);
    chk(q, 32'h0);
    $display("mode and unmapped done");
    periph_act <= 55'hff;
    periph_oe <= 55'hf0;
    periph_out <= 55'h3c;
    @(posedge clk);
    chk(pad_out[15:0], 16'h003c);
    bus(0, 4'hc, 32'h0);
    chk(q, 32'h000000f0);
    bus(0, 4'h2, 32'h0);
    chk(q, 32'hffffff3f);
    $display("peripheral drive done");
    periph_act <= '0;
    bus(1, 4'h0, 32'h0000ff00);
    rst_n <= 1'b0;
    @(posedge clk);
    chk(&pad_oe_n && !pull_on && !irq_active, 1'b1);
    rst_n <= 1'b1;
    bus(0, 4'h0, 32'h0);
    chk(q, 32'h0);
    $display("second reset done");
    conclude();
  end
endmodule : tb_spc_pin_ctrl
